// ===== design/cad_decoder.sv
// operand addressing mode decoder and effective address sequencer
// Summary of operation
// [RULE1] short forms reach page zero, fewer bytes
// [RULE2] long forms reach whole 64 Kbyte space
// [RULE3] memory read-modify-write uses short forms only
// [RULE4] inherent: one byte, no operand fetch
// [RULE5] immediate: opcode then literal operand byte
// [RULE6] short direct: one address byte, page zero
// [RULE7] long direct: two address bytes, full space
// [RULE8] indexed: unsigned sum of index and offset
// [RULE9] no-offset indexed: index alone, no byte
// [RULE10] short indexed: one offset byte, carry kept
// [RULE11] long indexed: two offset bytes plus index
// [RULE12] short indirect: byte pointer read from page zero
// [RULE13] long indirect: word pointer, full space
// [RULE14] indirect indexed: pointer plus index register
// [RULE15] mask op level 3, unmask op level 0
// [RULE16] sleep until interrupt; halt stops oscillator
// [RULE17] relative: pc plus signed 8-bit offset
// [RULE18] prefix 90 selects second index register
// [RULE19] prefix 92 turns forms into indirect forms
// [RULE20] prefix 91 indirect indexed on second index
// [RULE21] pc and length count every instruction byte
`timescale 1ns/1ps
`default_nettype none
module cad_decoder
   import cad_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        reset_n,
   input  wire logic [7:0]  mem_rdata,
   input  wire logic        mem_ack,
   input  wire logic [7:0]  index_x,
   input  wire logic [7:0]  index_y,
   input  wire logic        irq_req,
   input  wire logic        branch_take,
   output logic             mem_req,
   output logic [15:0]      mem_addr,
   output logic [15:0]      pc,
   output logic [7:0]       opcode,
   output cad_mode_e        mode,
   output logic             second_index,
   output logic             rmw,
   output logic [7:0]       operand,
   output logic [15:0]      ea,
   output logic             ea_valid,
   output logic             inst_done,
   output logic [2:0]       inst_len,
   output logic [1:0]       irq_level,
   output logic             carry,
   output logic             sp_reset,
   output logic             sleeping,
   output logic             osc_stop
);

   ////////////////////////////////////////////////////////////////////////////
   // decode functions

   function automatic cad_mode_e decode_mode(input logic [7:0] op,
                                             input logic       ind);
      cad_mode_e m;
      m = MODE_INHERENT;                                // see [RULE4]
      case (op[7:4])
         GRP_IMMEDIATE:   m = MODE_IMMEDIATE;           // see [RULE5]
         GRP_DIRECT_S,
         GRP_RMW_DIRECT:  m = ind ? MODE_INDIR_S  : MODE_DIRECT_S; // see [RULE19]
         GRP_DIRECT_L:    m = ind ? MODE_INDIR_L  : MODE_DIRECT_L; // see [RULE19]
         GRP_INDEX_0,
         GRP_RMW_INDEX_0: m = MODE_INDEX_0;             // see [RULE9]
         GRP_INDEX_S,
         GRP_RMW_INDEX_S: m = ind ? MODE_INDIDX_S : MODE_INDEX_S; // see [RULE19]
         GRP_INDEX_L:     m = ind ? MODE_INDIDX_L : MODE_INDEX_L; // see [RULE19]
         GRP_RELATIVE:    m = ind ? MODE_REL_IND  : MODE_REL;     // see [RULE19]
         default:         m = MODE_INHERENT;
      endcase
      return m;
   endfunction

   // memory rmw groups exist only in short forms
   function automatic logic is_rmw(input logic [7:0] op);
      return (op[7:4] == GRP_RMW_DIRECT) || (op[7:4] == GRP_RMW_INDEX_S) ||
             (op[7:4] == GRP_RMW_INDEX_0);             // see [RULE3]
   endfunction

   // bytes that follow the opcode in the fetch stream
   function automatic logic [1:0] arg_bytes(input cad_mode_e m);
      logic [1:0] n;
      n = 2'h0;
      case (m)
         MODE_IMMEDIATE, MODE_DIRECT_S, MODE_INDEX_S, MODE_REL,
         MODE_INDIR_S, MODE_INDIR_L, MODE_INDIDX_S, MODE_INDIDX_L,
         MODE_REL_IND:  n = 2'h1;                       // see [RULE1]
         MODE_DIRECT_L,
         MODE_INDEX_L:  n = 2'h2;                       // see [RULE2]
         default:       n = 2'h0;
      endcase
      return n;
   endfunction

   // size of the pointer read from page zero
   function automatic logic [1:0] ptr_bytes(input cad_mode_e m);
      logic [1:0] n;
      n = 2'h0;
      case (m)
         MODE_INDIR_S, MODE_INDIDX_S, MODE_REL_IND: n = 2'h1; // see [RULE12]
         MODE_INDIR_L, MODE_INDIDX_L:               n = 2'h2; // see [RULE13]
         default:                                   n = 2'h0;
      endcase
      return n;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // state

   cad_state_e  state;
   logic [7:0]  b_hi;
   logic [7:0]  b_lo;
   logic [7:0]  ptr_addr;
   logic        pfx_ind;
   logic        pfx_second;
   logic [2:0]  len_cnt;

   ////////////////////////////////////////////////////////////////////////////
   // combinational selection

   wire        got        = mem_req & mem_ack;
   wire        is_pfx_90  = (mem_rdata == PFX_SECOND_INDEX);
   wire        is_pfx_91  = (mem_rdata == PFX_INDIRECT_SECOND_INDEX);
   wire        is_pfx_92  = (mem_rdata == PFX_INDIRECT);
   wire        is_prefix  = is_pfx_90 | is_pfx_91 | is_pfx_92;
   wire cad_mode_e next_mode = decode_mode(mem_rdata, pfx_ind);
   wire [1:0]  n_args     = arg_bytes(mode);
   wire [1:0]  n_ptr      = ptr_bytes(mode);
   wire [1:0]  n_args_new = arg_bytes(next_mode);

   wire        need_rd    = (state == ST_OPCODE) || (state == ST_ARG1) ||
                            (state == ST_ARG2) || (state == ST_PTR1) ||
                            (state == ST_PTR2);
   wire [15:0] ptr_base   = {PAGE_ZERO_HI, ptr_addr};
   wire [15:0] req_addr   = (state == ST_PTR1) ? ptr_base :
                            (state == ST_PTR2) ? ptr_base + 16'h0001 :
                            pc;

   wire        indexed    = (mode == MODE_INDEX_0) || (mode == MODE_INDEX_S) ||
                            (mode == MODE_INDEX_L) || (mode == MODE_INDIDX_S) ||
                            (mode == MODE_INDIDX_L);
   wire        relative   = (mode == MODE_REL) || (mode == MODE_REL_IND);
   wire [7:0]  idx_val    = second_index ? index_y : index_x; // see [RULE18]
   wire [15:0] idx_add    = indexed ? {8'h00, idx_val} : 16'h0000;
   wire [15:0] base       = {b_hi, b_lo};
   // short forms keep b_hi at zero, so the sum carries into bit 8
   wire [15:0] sum_ea     = base + idx_add;          // see [RULE8] [RULE10]
   wire [15:0] rel_ea     = pc + {{8{b_lo[7]}}, b_lo}; // see [RULE17]
   wire [15:0] next_ea    = relative ? rel_ea : sum_ea;
   wire        addressed  = (mode != MODE_INHERENT) &&
                            (mode != MODE_IMMEDIATE);
   wire        inh_op     = (mode == MODE_INHERENT) &&
                            (opcode[7:4] == GRP_INHERENT);
   wire [3:0]  inh_code   = opcode[3:0];

   ////////////////////////////////////////////////////////////////////////////
   // sequencer

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         state        <= ST_OPCODE;
         mem_req      <= 1'b0;
         mem_addr     <= 16'h0000;
         pc           <= PC_RESET;
         opcode       <= 8'h00;
         mode         <= MODE_INHERENT;
         second_index <= 1'b0;
         rmw          <= 1'b0;
         operand      <= 8'h00;
         ea           <= 16'h0000;
         ea_valid     <= 1'b0;
         inst_done    <= 1'b0;
         inst_len     <= 3'h0;
         irq_level    <= IRQ_LEVEL_RESET;
         carry        <= 1'b0;
         sp_reset     <= 1'b0;
         sleeping     <= 1'b0;
         osc_stop     <= 1'b0;
         b_hi         <= 8'h00;
         b_lo         <= 8'h00;
         ptr_addr     <= 8'h00;
         pfx_ind      <= 1'b0;
         pfx_second   <= 1'b0;
         len_cnt      <= 3'h0;
      end else begin
         ea_valid  <= 1'b0;
         inst_done <= 1'b0;
         sp_reset  <= 1'b0;
         if (need_rd && !mem_req) begin
            mem_req  <= 1'b1;
            mem_addr <= req_addr;
         end
         if (got) begin
            mem_req <= 1'b0;
         end
         case (state)
            ST_OPCODE: begin
               if (got) begin
                  pc      <= pc + 16'h0001;               // see [RULE21]
                  len_cnt <= len_cnt + 3'h1;              // see [RULE21]
                  if (is_prefix) begin
                     pfx_ind    <= pfx_ind | is_pfx_91 | is_pfx_92;
                     pfx_second <= pfx_second | is_pfx_90 | is_pfx_91; // see [RULE20]
                  end else begin
                     opcode       <= mem_rdata;
                     mode         <= next_mode;
                     rmw          <= is_rmw(mem_rdata);   // see [RULE3]
                     second_index <= pfx_second;          // see [RULE18]
                     b_hi         <= 8'h00;
                     b_lo         <= 8'h00;
                     state        <= (n_args_new == 2'h0) ? ST_EXEC : ST_ARG1; // see [RULE4]
                  end
               end
            end
            ST_ARG1: begin
               if (got) begin
                  pc      <= pc + 16'h0001;               // see [RULE21]
                  len_cnt <= len_cnt + 3'h1;
                  if (n_args == 2'h2) begin
                     b_hi  <= mem_rdata;                  // see [RULE7] [RULE11]
                     state <= ST_ARG2;
                  end else begin
                     b_lo     <= mem_rdata;               // see [RULE6]
                     ptr_addr <= mem_rdata;
                     state    <= (n_ptr == 2'h0) ? ST_EXEC : ST_PTR1;
                  end
               end
            end
            ST_ARG2: begin
               if (got) begin
                  pc      <= pc + 16'h0001;
                  len_cnt <= len_cnt + 3'h1;
                  b_lo    <= mem_rdata;
                  state   <= ST_EXEC;
               end
            end
            ST_PTR1: begin
               if (got) begin
                  if (n_ptr == 2'h2) begin
                     b_hi  <= mem_rdata;                  // see [RULE13]
                     state <= ST_PTR2;
                  end else begin
                     b_hi  <= 8'h00;                      // see [RULE12]
                     b_lo  <= mem_rdata;
                     state <= ST_EXEC;
                  end
               end
            end
            ST_PTR2: begin
               if (got) begin
                  b_lo  <= mem_rdata;                     // see [RULE14]
                  state <= ST_EXEC;
               end
            end
            ST_EXEC: begin
               ea         <= next_ea;
               ea_valid   <= addressed;
               inst_done  <= 1'b1;
               inst_len   <= len_cnt;                     // see [RULE21]
               len_cnt    <= 3'h0;
               pfx_ind    <= 1'b0;
               pfx_second <= 1'b0;
               state      <= ST_OPCODE;
               if (mode == MODE_IMMEDIATE) begin
                  operand <= b_lo;                        // see [RULE5]
               end
               if (relative && branch_take) begin
                  pc <= rel_ea;                           // see [RULE17]
               end
               if (inh_op) begin
                  if (inh_code == OP_MASK_IRQ) begin
                     irq_level <= IRQ_LEVEL_MASKED;       // see [RULE15]
                  end else if (inh_code == OP_UNMASK_IRQ) begin
                     irq_level <= IRQ_LEVEL_OPEN;         // see [RULE15]
                  end else if (inh_code == OP_CARRY_SET) begin
                     carry <= 1'b1;
                  end else if (inh_code == OP_CARRY_CLEAR) begin
                     carry <= 1'b0;
                  end else if (inh_code == OP_STACK_POINTER_RST) begin
                     sp_reset <= 1'b1;
                  end else if (inh_code == OP_SLEEP_UNTIL_IRQ) begin
                     sleeping <= 1'b1;                    // see [RULE16]
                     state    <= ST_SLEEP;
                  end else if (inh_code == OP_HALT) begin
                     osc_stop <= 1'b1;                    // see [RULE16]
                     state    <= ST_HALT;
                  end
               end
            end
            ST_SLEEP: begin
               if (irq_req) begin
                  sleeping <= 1'b0;                       // see [RULE16]
                  state    <= ST_OPCODE;
               end
            end
            ST_HALT: begin
               if (irq_req) begin
                  osc_stop <= 1'b0;
                  state    <= ST_OPCODE;
               end
            end
            default: begin
               state <= ST_OPCODE;
            end
         endcase
      end
   end

endmodule
`default_nettype wire

// ===== design/cad_pkg.sv
// constants and types for the operand addressing decoder
package cad_pkg;

   // prefix byte values
   localparam logic [7:0] PFX_SECOND_INDEX          = 8'h90;
   localparam logic [7:0] PFX_INDIRECT_SECOND_INDEX = 8'h91;
   localparam logic [7:0] PFX_INDIRECT              = 8'h92;

   // opcode group, taken from the high nibble
   localparam logic [3:0] GRP_INHERENT     = 4'h0;
   localparam logic [3:0] GRP_RELATIVE     = 4'h2;
   localparam logic [3:0] GRP_RMW_DIRECT   = 4'h3;
   localparam logic [3:0] GRP_RMW_INDEX_S  = 4'h6;
   localparam logic [3:0] GRP_RMW_INDEX_0  = 4'h7;
   localparam logic [3:0] GRP_IMMEDIATE    = 4'ha;
   localparam logic [3:0] GRP_DIRECT_S     = 4'hb;
   localparam logic [3:0] GRP_DIRECT_L     = 4'hc;
   localparam logic [3:0] GRP_INDEX_L      = 4'hd;
   localparam logic [3:0] GRP_INDEX_S      = 4'he;
   localparam logic [3:0] GRP_INDEX_0      = 4'hf;

   // inherent operations, low nibble of a group 0 opcode
   localparam logic [3:0] OP_MASK_IRQ          = 4'h1;
   localparam logic [3:0] OP_UNMASK_IRQ        = 4'h2;
   localparam logic [3:0] OP_SLEEP_UNTIL_IRQ   = 4'h3;
   localparam logic [3:0] OP_HALT              = 4'h4;
   localparam logic [3:0] OP_CARRY_SET         = 4'h5;
   localparam logic [3:0] OP_CARRY_CLEAR       = 4'h6;
   localparam logic [3:0] OP_STACK_POINTER_RST = 4'h7;

   // interrupt mask levels and reset values
   localparam logic [1:0]  IRQ_LEVEL_MASKED = 2'h3;
   localparam logic [1:0]  IRQ_LEVEL_OPEN   = 2'h0;
   localparam logic [1:0]  IRQ_LEVEL_RESET  = 2'h3;
   localparam logic [15:0] PC_RESET         = 16'h0000;
   localparam logic [7:0]  PAGE_ZERO_HI     = 8'h00;

   typedef enum logic [3:0] {
      MODE_INHERENT,
      MODE_IMMEDIATE,
      MODE_DIRECT_S,
      MODE_DIRECT_L,
      MODE_INDEX_0,
      MODE_INDEX_S,
      MODE_INDEX_L,
      MODE_INDIR_S,
      MODE_INDIR_L,
      MODE_INDIDX_S,
      MODE_INDIDX_L,
      MODE_REL,
      MODE_REL_IND
   } cad_mode_e;

   typedef enum logic [2:0] {
      ST_OPCODE,
      ST_ARG1,
      ST_ARG2,
      ST_PTR1,
      ST_PTR2,
      ST_EXEC,
      ST_SLEEP,
      ST_HALT
   } cad_state_e;

endpackage

// ===== verification/cad_decoder_chk.sv
// concurrent checks on the addressing decoder ports
`timescale 1ns/1ps
`default_nettype none
module cad_decoder_chk
   import cad_pkg::*;
(
   input wire logic        clk_sys,
   input wire logic        reset_n,
   input wire logic        mem_ack,
   input wire logic [7:0]  index_x,
   input wire logic [7:0]  index_y,
   input wire logic        branch_take,
   input wire logic        mem_req,
   input wire logic [15:0] mem_addr,
   input wire logic [15:0] pc,
   input wire logic [7:0]  opcode,
   input wire cad_mode_e   mode,
   input wire logic        second_index,
   input wire logic [15:0] ea,
   input wire logic        ea_valid,
   input wire logic        inst_done,
   input wire logic [2:0]  inst_len,
   input wire logic [1:0]  irq_level,
   input wire logic        sleeping,
   input wire logic        osc_stop
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   ////////////////////////////////////////////////////////////////////////////
   property p_hold;
      mem_req && !mem_ack |=> mem_req && $stable(mem_addr);
   endproperty
   a_hold: assert property (p_hold)
      else $error("read dropped early");
   property p_gap;
      mem_req && mem_ack |=> !mem_req;
   endproperty
   a_gap: assert property (p_gap)
      else $error("no gap after read");
   property p_fetch;
      inst_done && !sleeping && !osc_stop |=> mem_req && mem_addr == pc;
   endproperty
   a_fetch: assert property (p_fetch)
      else $error("fetch not at pc");
   property p_inh_len;
      inst_done && mode == MODE_INHERENT && !second_index |-> inst_len == 3'h1;
   endproperty
   a_inh_len: assert property (p_inh_len)
      else $error("bad length");
   property p_imm_len;
      inst_done && mode == MODE_IMMEDIATE && !second_index |-> inst_len == 3'h2;
   endproperty
   a_imm_len: assert property (p_imm_len)
      else $error("bad length");
   property p_long_len;
      inst_done && mode inside {MODE_DIRECT_L, MODE_INDEX_L} && !second_index
         |-> inst_len == 3'h3;
   endproperty
   a_long_len: assert property (p_long_len)
      else $error("bad length");
   property p_page0;
      ea_valid && mode inside {MODE_DIRECT_S, MODE_INDEX_0, MODE_INDIR_S}
         |-> ea[15:8] == PAGE_ZERO_HI;
   endproperty
   a_page0: assert property (p_page0)
      else $error("left page zero");
   property p_idx0;
      ea_valid && mode == MODE_INDEX_0
         |-> ea == {8'h00, second_index ? $past(index_y) : $past(index_x)};
   endproperty
   a_idx0: assert property (p_idx0)
      else $error("bad index ea");
   property p_rel;
      inst_done && mode == MODE_REL && $past(branch_take) |-> pc == ea;
   endproperty
   a_rel: assert property (p_rel)
      else $error("branch not taken");
   property p_mask;
      inst_done && opcode inside {8'h01, 8'h02}
         |-> irq_level == (opcode[1] ? IRQ_LEVEL_OPEN : IRQ_LEVEL_MASKED);
   endproperty
   a_mask: assert property (p_mask)
      else $error("bad mask level");
   property p_quiet;
      sleeping || osc_stop |-> !mem_req;
   endproperty
   a_quiet: assert property (p_quiet)
      else $error("fetch while idle");
   c_indidx: cover property (ea_valid && mode == MODE_INDIDX_L);
   c_wake: cover property (sleeping ##1 !sleeping);
   c_taken: cover property (inst_done && mode == MODE_REL && pc == ea);
endmodule
bind cad_decoder cad_decoder_chk i_cad_decoder_chk (
   .clk_sys(clk_sys), .reset_n(reset_n), .mem_ack(mem_ack),
   .index_x(index_x), .index_y(index_y), .branch_take(branch_take),
   .mem_req(mem_req), .mem_addr(mem_addr), .pc(pc), .opcode(opcode),
   .mode(mode), .second_index(second_index), .ea(ea), .ea_valid(ea_valid),
   .inst_done(inst_done), .inst_len(inst_len), .irq_level(irq_level),
   .sleeping(sleeping), .osc_stop(osc_stop)
);
`default_nettype wire

// ===== verification/cad_mem_model.sv
// program and data memory answering the decoder reads
`timescale 1ns/1ps
`default_nettype none
module cad_mem_model (
   input  wire logic        clk_sys,
   input  wire logic        reset_n,
   input  wire logic        mem_req,
   input  wire logic [15:0] mem_addr,
   input  wire logic [1:0]  slow,
   output logic             mem_ack,
   output logic [7:0]       mem_rdata
);
   logic [7:0] mem [0:65535];
   logic [1:0] waited;
   initial begin
      foreach (mem[a]) begin
         mem[a] = 8'h00;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // data line toggles outside the ack cycle
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         mem_ack <= 1'b0;
         waited <= 2'h0;
         mem_rdata <= 8'h5a;
      end else if (mem_req && !mem_ack && waited >= slow) begin
         mem_ack <= 1'b1;
         mem_rdata <= mem[mem_addr];
         waited <= 2'h0;
      end else begin
         mem_ack <= 1'b0;
         mem_rdata <= ~mem_rdata;
         if (mem_req && !mem_ack) begin
            waited <= waited + 2'h1;
         end
      end
   end
endmodule
`default_nettype wire

// ===== verification/test_cad_decoder.sv
// self-checking bench for the addressing decoder
`timescale 1ns/1ps
`default_nettype none
module test_cad_decoder
   import cad_pkg::*;
;
   typedef struct packed {
      logic [31:0] code;
      logic [2:0]  len;
      cad_mode_e   mode;
      logic [15:0] ea;
      logic        sec;
      logic        rmw;
   } cad_row_s;
   logic        clk_sys, reset_n, mem_ack, irq_req, branch_take, mem_req;
   logic [7:0]  mem_rdata, index_x, index_y, opcode, operand;
   logic [1:0]  slow, irq_level;
   logic [15:0] mem_addr, pc, ea, addr;
   logic [2:0]  inst_len;
   cad_mode_e   mode;
   logic        second_index, rmw, ea_valid, inst_done, carry, sp_reset;
   logic        sleeping, osc_stop;
   int          failures, checks_done;
   cad_row_s rows [18] = '{
      '{32'h02000000, 3'h1, MODE_INHERENT,  16'h0000, 1'b0, 1'b0},
      '{32'ha6550000, 3'h2, MODE_IMMEDIATE, 16'h0055, 1'b0, 1'b0},
      '{32'hb6800000, 3'h2, MODE_DIRECT_S,  16'h0080, 1'b0, 1'b0},
      '{32'hc6123400, 3'h3, MODE_DIRECT_L,  16'h1234, 1'b0, 1'b0},
      '{32'hf6000000, 3'h1, MODE_INDEX_0,   16'h00f0, 1'b0, 1'b0},
      '{32'he6200000, 3'h2, MODE_INDEX_S,   16'h0110, 1'b0, 1'b0},
      '{32'hd6120000, 3'h3, MODE_INDEX_L,   16'h12f0, 1'b0, 1'b0},
      '{32'h90e62000, 3'h3, MODE_INDEX_S,   16'h0057, 1'b1, 1'b0},
      '{32'h92b68000, 3'h3, MODE_INDIR_S,   16'h00c5, 1'b0, 1'b0},
      '{32'h92c68100, 3'h3, MODE_INDIR_L,   16'h1234, 1'b0, 1'b0},
      '{32'h92e68000, 3'h3, MODE_INDIDX_S,  16'h01b5, 1'b0, 1'b0},
      '{32'h92d68100, 3'h3, MODE_INDIDX_L,  16'h1324, 1'b0, 1'b0},
      '{32'h91e68000, 3'h3, MODE_INDIDX_S,  16'h00fc, 1'b1, 1'b0},
      '{32'h92c6ff00, 3'h3, MODE_INDIR_L,   16'h5678, 1'b0, 1'b0},
      '{32'h20050000, 3'h2, MODE_REL,       16'h002a, 1'b0, 1'b0},
      '{32'h20fe0000, 3'h2, MODE_REL,       16'h0025, 1'b0, 1'b0},
      '{32'h01000000, 3'h1, MODE_INHERENT,  16'h0000, 1'b0, 1'b0},
      '{32'h36800000, 3'h2, MODE_DIRECT_S,  16'h0080, 1'b0, 1'b1}};
   cad_decoder i_cad_decoder (.clk_sys(clk_sys), .reset_n(reset_n),
      .mem_rdata(mem_rdata), .mem_ack(mem_ack), .index_x(index_x),
      .index_y(index_y), .irq_req(irq_req), .branch_take(branch_take),
      .mem_req(mem_req), .mem_addr(mem_addr), .pc(pc), .opcode(opcode),
      .mode(mode), .second_index(second_index), .rmw(rmw), .operand(operand),
      .ea(ea), .ea_valid(ea_valid), .inst_done(inst_done),
      .inst_len(inst_len), .irq_level(irq_level), .carry(carry),
      .sp_reset(sp_reset), .sleeping(sleeping), .osc_stop(osc_stop));
   cad_mem_model i_cad_mem_model (.clk_sys(clk_sys), .reset_n(reset_n),
      .mem_req(mem_req), .mem_addr(mem_addr), .slow(slow),
      .mem_ack(mem_ack), .mem_rdata(mem_rdata));
   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [15:0] seen, exp);
      checks_done++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic stop_test;
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic put(input logic [31:0] code, input logic [2:0] len);
      for (int k = 0; k < int'(len); k++) begin
         i_cad_mem_model.mem[addr] = code[31-8*k -: 8];
         addr++;
      end
   endtask
   task automatic wait_done;
      int n;
      n = 0;
      @(negedge clk_sys);
      while (inst_done !== 1'b1 && n < 60) begin
         @(negedge clk_sys);
         n++;
      end
      check("done", inst_done, 1'b1);
   endtask
   task automatic doze(input logic [1:0] exp);
      wait_done();
      repeat (3) @(negedge clk_sys);
      check("idle", {sleeping, osc_stop}, exp);
      check("idle req", mem_req, 1'b0);
      irq_req = 1'b1;
      @(negedge clk_sys);
      irq_req = 1'b0;
      check("wake", {sleeping, osc_stop}, 2'b00);
   endtask
   task automatic reset_vals;
      check("pc", pc, PC_RESET);
      check("level", irq_level, IRQ_LEVEL_RESET);
      check("req", mem_req, 1'b0);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end
   initial begin
      #160000;
      failures++;
      stop_test();
   end
   initial begin
      reset_n = 1'b0;
      irq_req = 1'b0;
      branch_take = 1'b0;
      index_x = 8'hf0;
      index_y = 8'h37;
      slow = 2'h0;
      addr = 16'h0000;
      #1;
      foreach (rows[i]) put(rows[i].code, rows[i].len);
      put(32'h03040506, 3'h4);
      put(32'h07200400, 3'h3);
      addr = 16'h0080;
      put(32'hc5123400, 3'h3);
      addr = 16'h00ff;
      put(32'h56780000, 3'h2);
      addr = 16'h0035;
      put(32'h92208100, 3'h3);
      addr = 16'h0000;
      repeat (5) @(negedge clk_sys);
      reset_vals();
      reset_n = 1'b1;
      foreach (rows[i]) begin
         slow = 2'(i % 3);
         addr = addr + 16'(rows[i].len);
         wait_done();
         check("len", inst_len, rows[i].len);
         check("mode", 16'(mode), 16'(rows[i].mode));
         if (rows[i].mode == MODE_IMMEDIATE) begin
            check("operand", operand, rows[i].ea);
         end else if (rows[i].mode != MODE_INHERENT) begin
            check("ea", ea, rows[i].ea);
         end
         check("eav", ea_valid, rows[i].mode > MODE_IMMEDIATE);
         check("op", opcode, rows[i].code[31:28] == 4'h9 ?
               rows[i].code[23:16] : rows[i].code[31:24]);
         check("second", second_index, rows[i].sec);
         check("rmw", rmw, rows[i].rmw);
         check("pc", pc, addr);
         $display("row %0d done", i);
      end
      check("level", irq_level, IRQ_LEVEL_MASKED);
      doze(2'b10);
      doze(2'b01);
      $display("low power done");
      wait_done();
      check("carry", carry, 1'b1);
      wait_done();
      check("carry", carry, 1'b0);
      wait_done();
      check("sp", sp_reset, 1'b1);
      branch_take = 1'b1;
      wait_done();
      check("target", pc, 16'h0035);
      branch_take = 1'b0;
      $display("flags and branch done");
      wait_done();
      check("mode", 16'(mode), 16'(MODE_REL_IND));
      check("ea", ea, 16'h004a);
      check("len", inst_len, 3'h3);
      check("pc", pc, 16'h0038);
      $display("relative pointer done");
      reset_n = 1'b0;
      @(negedge clk_sys);
      reset_vals();
      reset_n = 1'b1;
      wait_done();
      check("level", irq_level, IRQ_LEVEL_OPEN);
      check("pc", pc, 16'h0001);
      $display("reset done");
      stop_test();
   end
endmodule
`default_nettype wire
